/* core/iodc_ctrl.sv */
// Interrupt output stage: configuration register, hold-off timer, pin drive.
// Assumes a synchronous register port on clk_sys and per-source levels already
// masked by the enable register elsewhere in the device.
`include "iodc_cfg.svh"
// Behaviour
// - Bits 31:24 hold the read/write hold-off length in 10 us steps.
// - Writing zero ends any interval, clears the counter, releases held interrupts.
// - A new non-zero length applies to interrupts after the write.
// - The power event interrupt bypasses the hold-off interval.
// - Writing one to bit 14 with a non-zero length reloads the counter from it and starts a fresh interval.
// - Bit 13 shows a running interval, during which enabled interrupts other than the power event stay off the pin.
// - Bit 12 shows the master request, ignoring enable and hold-off.
// - Bit 8 clear keeps the pin deasserted, internal status untouched.
// - Bit 4 picks active high when set, low when clear, push-pull only.
// - Bit 0 clear is open-drain active low; set is push-pull.
module iodc_ctrl #(
   parameter int NSRC = 32,
   parameter int STEP_CYC = `IODC_STEP_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire iodc_pkg::iodc_req_s req,
   output logic [31:0] rdata,
   input wire logic [NSRC-1:0] src_active,
   input wire logic power_event_signal,
   output iodc_pkg::iodc_pin_s irq_pin
);
   import iodc_pkg::*;

   logic [7:0] holdoff_interval;
   logic irq_enable;
   logic pin_polarity;
   logic pushpull;
   logic [7:0] steps;
   logic holding;
   logic asserted;
   logic tick;
   logic [31:0] rd_reg;

   // Elaboration checks on the parameters
   if (NSRC < 1) begin : g_bad_nsrc
      $error("NSRC must be at least 1");
   end
   if (STEP_CYC < 2) begin : g_bad_step
      $error("STEP_CYC too small");
   end

   // Decode of the single configuration word
   wire cfg_hit = (req.addr == `IODC_CFG_OFFSET);
   wire cfg_wr = req.wr && cfg_hit;
   wire [7:0] wr_len = req.wdata[`IODC_HOLDOFF_MSB:`IODC_HOLDOFF_LSB];
   wire wr_zero = cfg_wr && (wr_len == 8'h00);
   wire holdoff_restart = cfg_wr && req.wdata[`IODC_RESTART_BIT];

   // Master request; status gating lives upstream so enable does not touch it
   wire master_req = |src_active;
   // Power event skips the hold-off gate entirely
   wire gated_req = (master_req && !holding) || power_event_signal;
   wire next_asserted = gated_req && irq_enable;
   wire released = asserted && !next_asserted;
   wire expire = holding && tick && (steps == 8'h01);
   wire start_hold = (holdoff_restart && !wr_zero)
                  || (released && holdoff_interval != 8'h00 && !wr_zero);

   iodc_tick #(
      .STEP_CYC(STEP_CYC)
   ) u_tick (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .restart(start_hold),
      .tick(tick)
   );

   // Writable fields, all zero after reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         holdoff_interval <= 8'h00;
         irq_enable <= 1'b0;
         pin_polarity <= 1'b0;
         pushpull <= 1'b0;
      end else if (cfg_wr) begin
         holdoff_interval <= wr_len;
         irq_enable <= req.wdata[`IODC_ENABLE_BIT];
         pin_polarity <= req.wdata[`IODC_POL_BIT];
         pushpull <= req.wdata[`IODC_TYPE_BIT];
      end
   end

   // Hold-off counter; the zero write beats a simultaneous start
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         holding <= 1'b0;
         steps <= 8'h00;
      end else if (wr_zero) begin
         holding <= 1'b0;
         steps <= 8'h00;
      end else if (start_hold) begin
         holding <= 1'b1;
         steps <= holdoff_restart ? wr_len : holdoff_interval;
      end else if (expire) begin
         holding <= 1'b0;
         steps <= 8'h00;
      end else if (holding && tick) begin
         steps <= steps - 8'h01;
      end
   end

   // Pin state register keeps the drive glitch free
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) asserted <= 1'b0;
      else asserted <= next_asserted;
   end

   // Open-drain pulls low only when asserted; push-pull drives level always
   assign irq_pin.oe = pushpull ? 1'b1 : asserted;
   assign irq_pin.out = pushpull ? (asserted ~^ pin_polarity) : 1'b0;

   // Read view; reserved bits zero, restart bit reads zero
   always_comb begin
      rd_reg = '0;
      rd_reg[`IODC_HOLDOFF_MSB:`IODC_HOLDOFF_LSB] = holdoff_interval;
      rd_reg[`IODC_ACTIVE_BIT] = holding;
      rd_reg[`IODC_MASTER_BIT] = master_req;
      rd_reg[`IODC_ENABLE_BIT] = irq_enable;
      rd_reg[`IODC_POL_BIT] = pin_polarity;
      rd_reg[`IODC_TYPE_BIT] = pushpull;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) rdata <= 32'h0000_0000;
      else if (req.rd && cfg_hit) rdata <= rd_reg;
   end

   a_enable_gates_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
      !irq_enable |=> !asserted) else $error("pin asserted while disabled");
   a_hold_blocks_req: assert property (@(posedge clk_sys) disable iff (!nrst)
      (holding && !power_event_signal) |=> !asserted)
      else $error("request passed during hold-off");
   a_pme_bypass: assert property (@(posedge clk_sys) disable iff (!nrst)
      (power_event_signal && irq_enable) |=> asserted)
      else $error("power event delayed");
   a_zero_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_zero |=> (!holding && steps == 8'h00)) else $error("zero write kept hold");
   a_restart_starts: assert property (@(posedge clk_sys) disable iff (!nrst)
      (holdoff_restart && !wr_zero) |=> (holding && steps == $past(wr_len)))
      else $error("restart did not start interval");
   a_release_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
      (released && holdoff_interval != 8'h00 && !cfg_wr) |=> holding)
      else $error("release did not start hold");
   a_master_status: assert property (@(posedge clk_sys) disable iff (!nrst)
      (req.rd && cfg_hit) |=> (rdata[`IODC_MASTER_BIT] == $past(|src_active)))
      else $error("master bit wrong");
   a_open_drain_low: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!pushpull && irq_pin.oe) |-> (irq_pin.out == 1'b0 && asserted))
      else $error("open-drain drive wrong");
   a_pushpull_level: assert property (@(posedge clk_sys) disable iff (!nrst)
      pushpull |-> (irq_pin.oe && irq_pin.out == (pin_polarity ? asserted : !asserted)))
      else $error("push-pull level wrong");
   a_len_stored: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_wr |=> holdoff_interval == $past(wr_len)) else $error("length not stored");
   c_hold_expire: cover property (@(posedge clk_sys) disable iff (!nrst) expire);
   c_restart: cover property (@(posedge clk_sys) disable iff (!nrst) holding && holdoff_restart);
   c_pin_on: cover property (@(posedge clk_sys) disable iff (!nrst) !asserted ##1 asserted);
endmodule // iodc_ctrl

/* pkg/iodc_cfg.svh */
// Constants for the interrupt output stage: register offset, field positions,
// reset values and hold-off timing. Included by the package and the core.
`ifndef IODC_CFG_SVH
`define IODC_CFG_SVH
`define IODC_CFG_OFFSET 8'h54
`define IODC_HOLDOFF_MSB 31
`define IODC_HOLDOFF_LSB 24
`define IODC_RESTART_BIT 14
`define IODC_ACTIVE_BIT 13
`define IODC_MASTER_BIT 12
`define IODC_ENABLE_BIT 8
`define IODC_POL_BIT 4
`define IODC_TYPE_BIT 0
`define IODC_CFG_RESET 32'h0000_0000
`define IODC_STEP_NS 10000
`define IODC_CLK_NS 5
`define IODC_STEP_CYC (`IODC_STEP_NS / `IODC_CLK_NS)
`endif

/* pkg/iodc_pkg.sv */
// Types shared by the interrupt output stage.
// Assumes iodc_cfg.svh is on the include path.
package iodc_pkg;
   `include "iodc_cfg.svh"
   // Register bus request from the host interface
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } iodc_req_s;
   // Pin drive as two signals
   typedef struct packed {
      logic out;
      logic oe;
   } iodc_pin_s;
   typedef enum logic [1:0] {
      IODC_IDLE = 2'b00,
      IODC_HOLD = 2'b01
   } iodc_state_e;
endpackage

/* core/iodc_tick.sv */
// Divider making one pulse per hold-off step from the system clock.
// Assumes clk_sys at the rate given in iodc_cfg.svh.
`include "iodc_cfg.svh"
module iodc_tick #(
   parameter int STEP_CYC = `IODC_STEP_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic restart,
   output logic tick
);
   localparam int CW = $clog2(STEP_CYC);
   logic [CW-1:0] cnt;
   wire at_end = (cnt == CW'(STEP_CYC - 1));
   // Elaboration check: a step shorter than two clocks cannot be divided
   if (STEP_CYC < 2) begin : g_bad_step
      $error("STEP_CYC too small");
   end
   // Restart realigns the step so a fresh interval is a full length
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) cnt <= '0;
      else if (restart || at_end) cnt <= '0;
      else cnt <= cnt + 1'b1;
   end
   assign tick = at_end && !restart;
endmodule // iodc_tick

/* bench/iodc_host_irq.sv */
// Host interrupt input: resolves the pin wire and decodes a request.
// Assumes the bench mirrors the configured buffer type and polarity.
module iodc_host_irq (
   input wire logic out,
   input wire logic oe,
   input wire logic push_pull,
   input wire logic active_high,
   output logic irq_seen
);
   logic level;
   // Pull-up holds the wired-OR line high when nobody drives it
   assign level = oe ? out : 1'b1;
   assign irq_seen = push_pull ? (level == active_high) : !level;
endmodule // iodc_host_irq

/* bench/tb_top.sv */
// Bench for the interrupt output stage, hold-off step cut to 4 clocks.
// Assumes iodc_pkg and iodc_host_irq are compiled first.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import iodc_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   iodc_req_s req = '0;
   logic [31:0] rdata;
   logic [31:0] src = '0;
   logic pwr = 1'b0;
   iodc_pin_s irq_pin;
   logic pp = 1'b0;
   logic ah = 1'b0;
   logic seen;
   logic [31:0] v;
   int n;
   int miscompares = 0;
   int cmp_count = 0;
   always #2.5 clk_sys = ~clk_sys;
   iodc_ctrl #(.NSRC(32), .STEP_CYC(4)) u_iodc_ctrl (.clk_sys(clk_sys), .nrst(nrst),
      .req(req), .rdata(rdata), .src_active(src), .power_event_signal(pwr), .irq_pin(irq_pin));
   iodc_host_irq u_iodc_host_irq (.out(irq_pin.out), .oe(irq_pin.oe), .push_pull(pp),
      .active_high(ah), .irq_seen(seen));
   task automatic check(string name, logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Write strobe lasts one cycle; the host model follows the new pin setup
   task automatic wr(logic [31:0] d);
      @(posedge clk_sys);
      req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h54, wdata: d};
      pp <= d[0];
      ah <= d[4];
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask
   // Bounded wait for the host to see the request; running out is a mismatch
   task automatic wait_irq(int lim);
      // Let the edge that took the last write settle before looking
      @(negedge clk_sys);
      for (n = 0; n < lim && seen !== 1'b1; n++) @(negedge clk_sys);
      if (n == lim) begin
         miscompares++;
         test_done();
      end
   endtask
   task automatic t_reset();
      rd(8'h54, v);
      check("cfg reset", v, 32'h0);
      check("pin reset", seen, 1'b0);
   endtask
   task automatic t_modes();
      src <= 32'h1;
      for (int i = 0; i < 4; i++) begin
         wr(32'h100 | i[1] << 4 | i[0]);
         wait_irq(4);
         check("drive", irq_pin.out, i[0] ? i[1] : 1'b0);
      end
      wr(32'h0);
      repeat (2) @(negedge clk_sys);
      check("disabled", seen, 1'b0);
      rd(8'h54, v);
      check("master", v[12], 1'b1);
      rd(8'h40, v);
      check("unmapped", v, 32'h1000);
   endtask
   task automatic t_holdoff();
      wr(32'h0200_0111);
      wait_irq(4);
      src <= 32'h0;
      rd(8'h54, v);
      check("active", v[13], 1'b1);
      src <= 32'h8000_0000;
      @(negedge clk_sys);
      check("held", seen, 1'b0);
      pwr <= 1'b1;
      wait_irq(3);
      pwr <= 1'b0;
      repeat (2) @(negedge clk_sys);
      wait_irq(12);
      check("interval", n > 3, 1'b1);
      src <= 32'h0;
      wr(32'h0200_4111);
      rd(8'h54, v);
      check("restart", v[14:13], 2'b01);
      src <= 32'h1;
      wr(32'h0000_0111);
      wait_irq(3);
   endtask
   // Reset for two cycles, then the scenarios in order
   initial begin
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      t_modes();
      t_holdoff();
      test_done();
   end
endmodule // tb_top
